/* rtl/spc_pin_ctrl.v */
// Pause / reset / data line three pin control behind the serial pins
`timescale 1ns/1ps
`include "spc_map.vh"

module spc_pin_ctrl (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Serial pins from the host
    input wire cs_n_pin,
    input wire sck_pin,
    // Data lines 3..0 (line 3 doubles as pause/reset input)
    input wire [3:0] io_in,
    output wire [3:0] io_out,
    output wire [3:0] io_oe,
    // Configuration from the status registers
    input wire quad_enable_bit,
    input wire role_reset_sel,
    // Command phase from the command decoder
    input wire quad_prog_active,
    input wire quad_read_active,
    input wire single_read_active,
    // Transmit data from the core
    input wire [3:0] tx_data,
    // Strobes and data to the core
    output wire sck_rise_q,
    output wire sck_fall_q,
    output wire [3:0] rx_data,
    output wire [2:0] bit_pos,
    output wire selected,
    output wire paused,
    output wire hw_reset_req
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    wire [`SPC_PIN_W-1:0] pin_sync;

    spc_sync #(
        .WIDTH(`SPC_PIN_W)
    ) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({cs_n_pin, sck_pin, io_in}),
        .sync_out(pin_sync)
    );

    wire cs_n_s;
    wire sck_s;
    wire [3:0] io_s;

    assign cs_n_s = pin_sync[`SPC_PIN_CSN];
    assign sck_s = pin_sync[`SPC_PIN_SCK];
    assign io_s = pin_sync[`SPC_PIN_IO_HI:`SPC_PIN_IO_LO];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg sck_prev_ff;
    reg [2:0] bit_pos_ff;
    reg [2:0] nxt_bit_pos;
    reg [3:0] rx_ff;
    reg [3:0] nxt_rx;
    reg [3:0] tx_ff;
    reg [3:0] nxt_tx;
    reg hw_reset_ff;
    reg nxt_hw_reset;

    // ----------------------------------------------------------------
    // Pin role decode
    // ----------------------------------------------------------------
    wire pin_role_free;
    wire pause_role;
    wire reset_role;
    wire line3_low;

    // Quad enable hands the pin to data only
    assign pin_role_free = ~quad_enable_bit;
    assign pause_role = pin_role_free
                        & (role_reset_sel == `SPC_ROLE_PAUSE);
    assign reset_role = pin_role_free
                        & (role_reset_sel == `SPC_ROLE_RESET);
    assign line3_low = ~io_s[`SPC_IO_LINE3];

    // ----------------------------------------------------------------
    // Clock edge detection
    // ----------------------------------------------------------------
    wire sck_rise;
    wire sck_fall;
    wire xfer_on;

    assign sck_rise = sck_s & ~sck_prev_ff;
    assign sck_fall = ~sck_s & sck_prev_ff;
    assign xfer_on = (state_ff == `SPC_ST_ACTIVE);

    // Edges count only while selected and not paused
    assign sck_rise_q = xfer_on & sck_rise;
    assign sck_fall_q = xfer_on & sck_fall;

    // ----------------------------------------------------------------
    // Transfer state machine
    // ----------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `SPC_ST_IDLE: begin
                if (!cs_n_s) begin
                    nxt_state = `SPC_ST_ACTIVE;
                end
            end
            `SPC_ST_ACTIVE: begin
                if (cs_n_s) begin
                    nxt_state = `SPC_ST_IDLE;
                end else if (pause_role && line3_low && !sck_s) begin
                    // Pause only starts with clock low
                    nxt_state = `SPC_ST_PAUSED;
                end
            end
            `SPC_ST_PAUSED: begin
                if (cs_n_s) begin
                    nxt_state = `SPC_ST_IDLE;
                end else if (!pause_role || !line3_low) begin
                    // Resume without touching the bit counter
                    nxt_state = `SPC_ST_ACTIVE;
                end
            end
            default: begin
                nxt_state = `SPC_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Bit position, receive and transmit data
    // ----------------------------------------------------------------
    always @* begin
        nxt_bit_pos = bit_pos_ff;
        nxt_rx = rx_ff;
        nxt_tx = tx_ff;
        if (state_ff == `SPC_ST_IDLE) begin
            nxt_bit_pos = 3'h0;
        end else if (sck_rise_q) begin
            // Position held while paused, so the transfer resumes
            nxt_bit_pos = bit_pos_ff + 3'h1;
            if (quad_prog_active) begin
                nxt_rx = io_s;
            end else begin
                nxt_rx = {3'h0, io_s[0]};
            end
        end
        if (sck_fall_q) begin
            nxt_tx = tx_data;
        end
    end

    // ----------------------------------------------------------------
    // Hardware reset request (reset role only)
    // ----------------------------------------------------------------
    always @* begin
        nxt_hw_reset = reset_role & line3_low;
    end

    // ----------------------------------------------------------------
    // Sequential logic
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= `SPC_ST_IDLE;
            // Matches the synchroniser's reset level, so no false edge
            sck_prev_ff <= 1'b1;
            bit_pos_ff <= 3'h0;
            rx_ff <= 4'h0;
            tx_ff <= 4'h0;
            hw_reset_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sck_prev_ff <= sck_s;
            bit_pos_ff <= nxt_bit_pos;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            hw_reset_ff <= nxt_hw_reset;
        end
    end

    // ----------------------------------------------------------------
    // Output drivers
    // ----------------------------------------------------------------
    wire drive_ok;
    wire quad_out;

    // Floats while deselected or paused
    assign drive_ok = xfer_on;
    // Lines zero, two and three drive only with quad enabled
    assign quad_out = drive_ok & quad_read_active & quad_enable_bit;

    assign io_oe[3] = quad_out;
    assign io_oe[2] = quad_out;
    assign io_oe[1] = drive_ok & (quad_read_active | single_read_active);
    assign io_oe[0] = quad_out;
    assign io_out = quad_read_active ? tx_ff : {2'h0, tx_ff[0], 1'b0};

    // ----------------------------------------------------------------
    // Core side outputs
    // ----------------------------------------------------------------
    assign rx_data = rx_ff;
    assign bit_pos = bit_pos_ff;
    assign selected = (state_ff != `SPC_ST_IDLE);
    assign paused = (state_ff == `SPC_ST_PAUSED);
    // Self-timed operations take no input from this block
    assign hw_reset_req = hw_reset_ff;

endmodule // spc_pin_ctrl

/* rtl/spc_map.vh */
// Constants for the pause / data line three pin control block
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// ----------------------------------------------------------------
// Pin role select (value of the role select bit)
// ----------------------------------------------------------------
`define SPC_ROLE_PAUSE 1'b0
`define SPC_ROLE_RESET 1'b1

// ----------------------------------------------------------------
// Transfer state codes
// ----------------------------------------------------------------
`define SPC_ST_IDLE 2'h0
`define SPC_ST_ACTIVE 2'h1
`define SPC_ST_PAUSED 2'h2

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define SPC_PIN_W 6
`define SPC_PIN_CSN 5
`define SPC_PIN_SCK 4
`define SPC_PIN_IO_HI 3
`define SPC_PIN_IO_LO 0
`define SPC_BITPOS_W 3
`define SPC_IO_LINE3 3
`define SPC_IO_SO 1

`endif

/* rtl/spc_sync.v */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module spc_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Asynchronous pins in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // ----------------------------------------------------------------
    // First stage is read only by the second
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule // spc_sync

/* verification/spc_pin_properties.sv */
// Checker for the pause / data line three pin control block
`timescale 1ns/1ps
module spc_chk (
    // Pins, configuration and core side
    input wire clk,
    input wire sys_rst,
    input wire [3:0] io_oe,
    input wire quad_enable_bit,
    input wire role_reset_sel,
    input wire quad_read_active,
    input wire sck_rise_q,
    input wire sck_fall_q,
    input wire [2:0] bit_pos,
    input wire selected,
    input wire paused
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_idle; !selected |-> io_oe == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("drive idle");
    property p_poff;
        paused |-> io_oe == 4'h0 && !sck_rise_q && !sck_fall_q;
    endproperty
    a_poff: assert property (p_poff) else $error("pause leak");
    property p_psel;
        paused && !$past(paused) |-> $past(selected) && $stable(bit_pos);
    endproperty
    a_psel: assert property (p_psel) else $error("pause desel");
    property p_hold; paused && $past(paused) |-> $stable(bit_pos); endproperty
    a_hold: assert property (p_hold) else $error("pos moved");
    property p_step; sck_rise_q |=> bit_pos - $past(bit_pos) == 3'h1; endproperty
    a_step: assert property (p_step) else $error("pos step");
    property p_qe; quad_enable_bit |=> !$rose(paused); endproperty
    a_qe: assert property (p_qe) else $error("quad pause");
    property p_role;
        $rose(paused) |-> !$past(role_reset_sel) && !$past(quad_enable_bit);
    endproperty
    a_role: assert property (p_role) else $error("role pause");
    property p_qrd;
        selected && !paused && quad_enable_bit && quad_read_active
            |-> io_oe == 4'hf;
    endproperty
    a_qrd: assert property (p_qrd) else $error("quad drive");
endmodule // spc_chk
bind spc_pin_ctrl spc_chk u_chk (.clk(clk), .sys_rst(sys_rst),
    .io_oe(io_oe), .quad_enable_bit(quad_enable_bit),
    .role_reset_sel(role_reset_sel), .quad_read_active(quad_read_active),
    .sck_rise_q(sck_rise_q), .sck_fall_q(sck_fall_q), .bit_pos(bit_pos),
    .selected(selected), .paused(paused));

/* verification/spc_host.sv */
// Host model driving select, clock, pause and data lines
`timescale 1ns/1ps
module spc_host (
    // Clock and device side of the lines
    input wire clk,
    input wire [3:0] io_out,
    input wire [3:0] io_oe,
    // Host pins
    output reg cs_n_pin,
    output reg sck_pin,
    output wire [3:0] io_in
);
    reg [3:0] h_d = 4'h0;
    reg h_oe = 1'b0;
    reg hold_n = 1'b1;
    reg [3:0] last = 4'h0;
    // Lines two, three pulled up; free lines toggle
    wire [3:0] rel = {hold_n, 1'b1, ~last[1:0]};
    assign io_in = (io_oe & io_out) | (~io_oe & (h_oe ? h_d : rel));
    initial begin
        cs_n_pin = 1'b1;
        sck_pin = 1'b0;
    end
    always @(posedge clk) begin
        last <= io_in;
    end
    task go(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task select(input v);
        go(1);
        cs_n_pin = v;
        go(4);
    endtask
    // Data set up half a period before the rise
    task bit_cyc(input [3:0] d);
        h_d = d;
        go(4);
        sck_pin = 1'b1;
        go(4);
        sck_pin = 1'b0;
    endtask
    // Called only while selected with the clock low
    task hold(input v);
        go(1);
        hold_n = v;
    endtask
endmodule // spc_host

/* verification/tb_spc_pin_ctrl.sv */
// Self-checking bench for the pin control block
`timescale 1ns/1ps
module tb_spc_pin_ctrl;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg qe = 1'b0;
    reg role = 1'b0;
    reg qprog = 1'b0;
    reg qread = 1'b0;
    reg sread = 1'b0;
    reg [3:0] tx = 4'h0;
    wire cs_n, sck, rise, fall, sel, pau, hwr;
    wire [3:0] io_in, io_out, io_oe, rx;
    wire [2:0] pos;
    integer error_cnt = 0;
    integer check_count = 0;
    spc_host u_spc_host (.clk(clk), .io_out(io_out), .io_oe(io_oe),
        .cs_n_pin(cs_n), .sck_pin(sck), .io_in(io_in));
    spc_pin_ctrl u_spc_pin_ctrl (.clk(clk), .sys_rst(sys_rst),
        .cs_n_pin(cs_n), .sck_pin(sck), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .quad_enable_bit(qe), .role_reset_sel(role),
        .quad_prog_active(qprog), .quad_read_active(qread),
        .single_read_active(sread), .tx_data(tx), .sck_rise_q(rise),
        .sck_fall_q(fall), .rx_data(rx), .bit_pos(pos), .selected(sel),
        .paused(pau), .hw_reset_req(hwr));
    initial begin
        forever #10 clk = ~clk;
    end
    task check(input [31:0] what, input [3:0] seen, input [3:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %0s exp %h seen %h", what, exp, seen);
        end
    endtask
    task t_qprog;
        qe = 1'b1;
        qprog = 1'b1;
        u_spc_host.h_oe = 1'b1;
        u_spc_host.select(1'b0);
        u_spc_host.bit_cyc(4'ha);
        u_spc_host.bit_cyc(4'h3);
        u_spc_host.bit_cyc(4'h5);
        u_spc_host.go(4);
        check("rx", rx, 4'h5);
        check("pos", {1'b0, pos}, 4'h3);
        check("pau", {3'h0, pau}, 4'h0);
        u_spc_host.select(1'b1);
        u_spc_host.h_oe = 1'b0;
        qprog = 1'b0;
        check("oe", io_oe, 4'h0);
    endtask
    task t_pause;
        qe = 1'b0;
        sread = 1'b1;
        tx = 4'h5;
        u_spc_host.select(1'b0);
        u_spc_host.bit_cyc(4'h0);
        u_spc_host.bit_cyc(4'h0);
        u_spc_host.hold(1'b0);
        u_spc_host.go(4);
        check("pau", {sel, pau}, 4'h3);
        check("oe", io_oe, 4'h0);
        check("hwr", {3'h0, hwr}, 4'h0);
        u_spc_host.bit_cyc(4'h0);
        check("pos", {1'b0, pos}, 4'h2);
        u_spc_host.hold(1'b1);
        u_spc_host.go(4);
        check("res", {pau, pos}, 4'h2);
        check("oe", io_oe, 4'h2);
        check("dout", io_out, 4'h2);
        u_spc_host.bit_cyc(4'h0);
        u_spc_host.go(4);
        check("pos", {1'b0, pos}, 4'h3);
        u_spc_host.select(1'b1);
        sread = 1'b0;
    endtask
    task t_role;
        role = 1'b1;
        u_spc_host.select(1'b0);
        u_spc_host.hold(1'b0);
        u_spc_host.go(5);
        check("rst", {hwr, pau}, 4'h2);
        u_spc_host.hold(1'b1);
        u_spc_host.go(5);
        check("rst", {hwr, pau}, 4'h0);
        u_spc_host.select(1'b1);
        role = 1'b0;
    endtask
    task t_qread;
        qe = 1'b1;
        qread = 1'b1;
        tx = 4'hc;
        u_spc_host.select(1'b0);
        u_spc_host.bit_cyc(4'h0);
        u_spc_host.go(4);
        check("out", io_out, 4'hc);
        check("oe", io_oe, 4'hf);
        tx = 4'h3;
        u_spc_host.bit_cyc(4'h0);
        u_spc_host.go(4);
        check("out", io_out, 4'h3);
        u_spc_host.select(1'b1);
        check("oe", io_oe, 4'h0);
        qread = 1'b0;
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        u_spc_host.bit_cyc(4'h1);
        check("idle", {sel, pos}, 4'h0);
        t_qprog;
        t_pause;
        t_role;
        t_qread;
        report_and_stop;
    end
endmodule // tb_spc_pin_ctrl
